// ### hdl/add_and_alu_ops.sv
`timescale 1ns/1ps
module add_and_alu_ops (
	input  wire logic                             i_clk,
	input  wire logic                             i_arst_n,
	input  wire logic [alu_core_pkg::INSTR_W-1:0] i_instr,
	input  wire logic                             i_instr_valid,
	output logic                                  o_instr_ready,
	output alu_core_pkg::file_req_t               o_file,
	input  wire logic [alu_core_pkg::BYTE_W-1:0]  i_file_rdata,
	input  wire alu_core_pkg::axil_req_t          i_axi,
	output alu_core_pkg::axil_rsp_t               o_axi
);

	// Register offset decode, shared by read and write paths
	function automatic alu_core_pkg::sel_t reg_decode(
		input logic [alu_core_pkg::ADDR_W-1:0] a
	);
		if (a == alu_core_pkg::ACC_OFS) begin
			reg_decode = alu_core_pkg::SEL_ACC;
		end else if (a == alu_core_pkg::STATUS_OFS) begin
			reg_decode = alu_core_pkg::SEL_STATUS;
		end else if (a == alu_core_pkg::CTRL_OFS) begin
			reg_decode = alu_core_pkg::SEL_CTRL;
		end else begin
			reg_decode = alu_core_pkg::SEL_NONE;
		end
	endfunction

	alu_core_pkg::phase_t              state_q;
	alu_core_pkg::op_t                 op_q;
	alu_core_pkg::op_t                 dec_op;
	alu_core_pkg::file_req_t           file_q;
	logic                              ready_q;
	logic                              valid_q;
	logic                              dest_file_q;
	logic [alu_core_pkg::BYTE_W-1:0]   lit_q;
	logic [alu_core_pkg::BYTE_W-1:0]   opnd_q;
	logic [alu_core_pkg::BYTE_W-1:0]   res_q;
	logic                              c_res_q;
	logic                              hc_res_q;
	logic                              z_res_q;
	logic [alu_core_pkg::BYTE_W-1:0]   acc_q;
	logic                              carry_q;
	logic                              half_carry_flag_q;
	logic                              zero_q;
	logic                              unsup_q;
	logic                              run_q;
	logic                              take;
	logic                              is_add;
	logic                              is_lit;
	logic                              is_file;
	logic [alu_core_pkg::BYTE_W-1:0]   opb;
	logic [alu_core_pkg::BYTE_W:0]     add_sum;
	logic [4:0]                        add_low;
	logic [alu_core_pkg::BYTE_W-1:0]   alu_res;
	logic                              hw_upd;

	// Opcode decode from the fetch stage word
	assign dec_op =
		(i_instr[13:9] == alu_core_pkg::PAT_ADD_LIT) ?
			alu_core_pkg::OP_ADD_LITERAL_TO_ACC :
		(i_instr[13:8] == alu_core_pkg::PAT_AND_LIT) ?
			alu_core_pkg::OP_AND_LITERAL_WITH_ACC :
		(i_instr[13:8] == alu_core_pkg::PAT_ADD_FILE) ?
			alu_core_pkg::OP_ADD_ACC_AND_FILE :
		(i_instr[13:8] == alu_core_pkg::PAT_AND_FILE) ?
			alu_core_pkg::OP_AND_ACC_WITH_FILE :
			alu_core_pkg::OP_NOP;
	assign take = (state_q == alu_core_pkg::PH_Q1) && ready_q && i_instr_valid;

	// Operand select and arithmetic
	assign is_add = (op_q == alu_core_pkg::OP_ADD_LITERAL_TO_ACC) ||
		(op_q == alu_core_pkg::OP_ADD_ACC_AND_FILE);
	assign is_lit = (op_q == alu_core_pkg::OP_ADD_LITERAL_TO_ACC) ||
		(op_q == alu_core_pkg::OP_AND_LITERAL_WITH_ACC);
	assign is_file = (dec_op == alu_core_pkg::OP_ADD_ACC_AND_FILE) ||
		(dec_op == alu_core_pkg::OP_AND_ACC_WITH_FILE);
	assign opb     = is_lit ? lit_q : opnd_q;
	assign add_sum = {1'b0, acc_q} + {1'b0, opb};
	assign add_low = {1'b0, acc_q[3:0]} + {1'b0, opb[3:0]};
	assign alu_res = is_add ? add_sum[7:0] : (acc_q & opb);
	assign hw_upd  = (state_q == alu_core_pkg::PH_Q4) && valid_q;

	// Four-phase sequencer, free running so the cycle rate is fixed
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= alu_core_pkg::PH_Q1;
			ready_q <= 1'b0;
		end else begin
			case (state_q)
				alu_core_pkg::PH_Q1: state_q <= alu_core_pkg::PH_Q2;
				alu_core_pkg::PH_Q2: state_q <= alu_core_pkg::PH_Q3;
				alu_core_pkg::PH_Q3: state_q <= alu_core_pkg::PH_Q4;
				default:             state_q <= alu_core_pkg::PH_Q1;
			endcase
			ready_q <= (state_q == alu_core_pkg::PH_Q4) && run_q;
		end
	end

	// Q1 decode, Q2 file read, Q3 process, Q4 write
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			op_q        <= alu_core_pkg::OP_NOP;
			valid_q     <= 1'b0;
			dest_file_q <= 1'b0;
			lit_q       <= 8'h00;
			opnd_q      <= 8'h00;
			res_q       <= 8'h00;
			c_res_q     <= 1'b0;
			hc_res_q    <= 1'b0;
			z_res_q     <= 1'b0;
			file_q      <= '0;
		end else begin
			if (take) begin
				op_q        <= dec_op;
				valid_q     <= (dec_op != alu_core_pkg::OP_NOP);
				dest_file_q <= is_file && i_instr[alu_core_pkg::DEST_BIT];
				lit_q       <= i_instr[7:0];
				file_q.rd   <= is_file;
				file_q.addr <= i_instr[6:0];
			end
			if (state_q == alu_core_pkg::PH_Q2) begin
				file_q.rd <= 1'b0;
				opnd_q    <= i_file_rdata;
			end
			if (state_q == alu_core_pkg::PH_Q3) begin
				res_q       <= alu_res;
				c_res_q     <= add_sum[8];
				hc_res_q    <= add_low[4];
				z_res_q     <= (alu_res == 8'h00);
				file_q.we    <= valid_q && dest_file_q;
				file_q.wdata <= alu_res;
			end
			if (state_q == alu_core_pkg::PH_Q4) begin
				file_q.we <= 1'b0;
				valid_q   <= 1'b0;
			end
		end
	end

	// AXI4-Lite slave state
	logic                              awready_q;
	logic                              wready_q;
	logic                              aw_full_q;
	logic                              w_full_q;
	logic [alu_core_pkg::ADDR_W-1:0]   awaddr_q;
	logic [alu_core_pkg::BYTE_W-1:0]   wbyte_q;
	logic                              wlane_q;
	logic                              bvalid_q;
	logic [1:0]                        bresp_q;
	logic                              arready_q;
	logic                              rvalid_q;
	logic [alu_core_pkg::DATA_W-1:0]   rdata_q;
	logic [1:0]                        rresp_q;
	logic                              aw_hs;
	logic                              w_hs;
	logic                              ar_hs;
	logic                              do_write;
	logic                              aw_full_d;
	logic                              w_full_d;
	logic                              bvalid_d;
	logic                              rvalid_d;
	alu_core_pkg::sel_t                wsel;
	alu_core_pkg::sel_t                rsel;
	logic                              wr_acc;
	logic                              wr_stat;
	logic                              wr_ctrl;
	logic [alu_core_pkg::DATA_W-1:0]   rd_mux;

	// Write side: address and data taken in either order
	assign aw_hs     = i_axi.awvalid && awready_q;
	assign w_hs      = i_axi.wvalid && wready_q;
	assign do_write  = aw_full_q && w_full_q && !bvalid_q;
	assign aw_full_d = (aw_full_q && !do_write) || aw_hs;
	assign w_full_d  = (w_full_q && !do_write) || w_hs;
	assign bvalid_d  = do_write || (bvalid_q && !i_axi.bready);
	assign wsel      = reg_decode(awaddr_q);
	assign wr_acc    = do_write && wlane_q && (wsel == alu_core_pkg::SEL_ACC);
	assign wr_stat   = do_write && wlane_q && (wsel == alu_core_pkg::SEL_STATUS);
	assign wr_ctrl   = do_write && wlane_q && (wsel == alu_core_pkg::SEL_CTRL);

	// Read side: one outstanding read, answer one cycle after the address
	assign ar_hs    = i_axi.arvalid && arready_q;
	assign rvalid_d = ar_hs || (rvalid_q && !i_axi.rready);
	assign rsel     = reg_decode(i_axi.araddr);
	assign rd_mux   =
		(rsel == alu_core_pkg::SEL_ACC) ? {24'h000000, acc_q} :
		(rsel == alu_core_pkg::SEL_STATUS) ?
			{28'h0000000, unsup_q, zero_q, half_carry_flag_q, carry_q} :
		(rsel == alu_core_pkg::SEL_CTRL) ? {31'h00000000, run_q} :
			32'h00000000;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awaddr_q  <= 4'h0;
			wbyte_q   <= 8'h00;
			wlane_q   <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= alu_core_pkg::RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= alu_core_pkg::RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			awready_q <= !aw_full_d;
			wready_q  <= !w_full_d;
			bvalid_q  <= bvalid_d;
			rvalid_q  <= rvalid_d;
			arready_q <= !rvalid_d;
			if (aw_hs) begin
				awaddr_q <= i_axi.awaddr;
			end
			if (w_hs) begin
				wbyte_q <= i_axi.wdata[7:0];
				wlane_q <= i_axi.wstrb[0];
			end
			if (do_write) begin
				bresp_q <= (wsel == alu_core_pkg::SEL_NONE) ?
					alu_core_pkg::RESP_SLVERR : alu_core_pkg::RESP_OKAY;
			end
			if (ar_hs) begin
				rdata_q <= rd_mux;
				rresp_q <= (rsel == alu_core_pkg::SEL_NONE) ?
					alu_core_pkg::RESP_SLVERR : alu_core_pkg::RESP_OKAY;
			end
		end
	end

	// Architectural state; a Q4 write beats a software write in the same cycle
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			acc_q             <= alu_core_pkg::ACC_RST;
			carry_q           <= 1'b0;
			half_carry_flag_q <= 1'b0;
			zero_q            <= 1'b0;
			unsup_q           <= 1'b0;
			run_q             <= alu_core_pkg::CTRL_RUN_RST;
		end else begin
			if (hw_upd) begin
				if (!dest_file_q) begin
					acc_q <= res_q;
				end
				zero_q <= z_res_q;
				if (is_add) begin
					carry_q           <= c_res_q;
					half_carry_flag_q <= hc_res_q;
				end
			end else begin
				if (wr_acc) begin
					acc_q <= wbyte_q;
				end
				if (wr_stat) begin
					carry_q           <= wbyte_q[alu_core_pkg::STAT_C_BIT];
					half_carry_flag_q <= wbyte_q[alu_core_pkg::STAT_HC_BIT];
					zero_q            <= wbyte_q[alu_core_pkg::STAT_Z_BIT];
				end
			end
			// Foreign opcodes are skipped; set beats the write-one clear
			unsup_q <= (take && (dec_op == alu_core_pkg::OP_NOP)) ||
				(unsup_q && !(wr_stat && wbyte_q[alu_core_pkg::STAT_UNSUP_BIT]));
			if (wr_ctrl) begin
				run_q <= wbyte_q[alu_core_pkg::CTRL_RUN_BIT];
			end
		end
	end

	assign o_instr_ready = ready_q;
	assign o_file        = file_q;
	assign o_axi         = {awready_q, wready_q, bvalid_q, bresp_q,
		arready_q, rvalid_q, rdata_q, rresp_q};

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	add_lit_sum_a: assert property (
		take && dec_op == alu_core_pkg::OP_ADD_LITERAL_TO_ACC |-> ##4
		acc_q == 8'($past(acc_q, 2) + $past(i_instr[7:0], 4)))
		else $error("add literal result wrong");
	add_file_read_a: assert property (
		take && dec_op == alu_core_pkg::OP_ADD_ACC_AND_FILE |=>
		file_q.rd && file_q.addr == $past(i_instr[6:0]) ##1 !file_q.rd)
		else $error("file read not issued in Q2");
	dest_select_a: assert property (
		take && is_file |-> ##3
		(file_q.we == $past(i_instr[alu_core_pkg::DEST_BIT], 3)) ##1 !file_q.we)
		else $error("destination select wrong");
	and_lit_flags_a: assert property (
		take && dec_op == alu_core_pkg::OP_AND_LITERAL_WITH_ACC |-> ##4
		carry_q == $past(carry_q, 4) && acc_q ==
		($past(acc_q, 2) & $past(i_instr[7:0], 4)))
		else $error("and literal wrong");
	and_file_data_a: assert property (
		take && dec_op == alu_core_pkg::OP_AND_ACC_WITH_FILE &&
		i_instr[alu_core_pkg::DEST_BIT] |-> ##3
		file_q.wdata == ($past(acc_q) & $past(i_file_rdata, 2)))
		else $error("and file write data wrong");
	phase_order_a: assert property (
		state_q == alu_core_pkg::PH_Q1 |=> state_q == alu_core_pkg::PH_Q2
		##1 state_q == alu_core_pkg::PH_Q3 ##1 state_q == alu_core_pkg::PH_Q4
		##1 state_q == alu_core_pkg::PH_Q1)
		else $error("phase sequence broken");
	add_carry_a: assert property (
		take && dec_op == alu_core_pkg::OP_ADD_LITERAL_TO_ACC |-> ##4
		carry_q == $past(add_sum[8], 2) && zero_q == (acc_q == 8'h00) &&
		half_carry_flag_q == $past(add_low[4], 2))
		else $error("add flags wrong");

endmodule

// ### common/alu_core_pkg.sv
package alu_core_pkg;

	// Widths
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 32;
	localparam int BYTE_W  = 8;
	localparam int FADR_W  = 7;
	localparam int INSTR_W = 14;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] ACC_OFS    = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h8;

	// Status and control field positions
	localparam int STAT_C_BIT     = 0;
	localparam int STAT_HC_BIT    = 1;
	localparam int STAT_Z_BIT     = 2;
	localparam int STAT_UNSUP_BIT = 3;
	localparam int CTRL_RUN_BIT   = 0;

	// Reset values
	localparam logic [BYTE_W-1:0] ACC_RST      = 8'h00;
	localparam logic              CTRL_RUN_RST = 1'b1;

	// Instruction word fields
	localparam int DEST_BIT = 7;
	localparam logic [4:0] PAT_ADD_LIT  = 5'h1F;
	localparam logic [5:0] PAT_AND_LIT  = 6'h39;
	localparam logic [5:0] PAT_ADD_FILE = 6'h07;
	localparam logic [5:0] PAT_AND_FILE = 6'h05;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} phase_t;

	typedef enum logic [4:0] {
		OP_NOP                  = 5'h01,
		OP_ADD_LITERAL_TO_ACC   = 5'h02,
		OP_ADD_ACC_AND_FILE     = 5'h04,
		OP_AND_LITERAL_WITH_ACC = 5'h08,
		OP_AND_ACC_WITH_FILE    = 5'h10
	} op_t;

	typedef enum logic [3:0] {
		SEL_ACC    = 4'h1,
		SEL_STATUS = 4'h2,
		SEL_CTRL   = 4'h4,
		SEL_NONE   = 4'h8
	} sel_t;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axil_req_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} axil_rsp_t;

	typedef struct packed {
		logic              rd;
		logic              we;
		logic [FADR_W-1:0] addr;
		logic [BYTE_W-1:0] wdata;
	} file_req_t;

endpackage

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic [3:0] RA = alu_core_pkg::ACC_OFS;
	localparam logic [3:0] RS = alu_core_pkg::STATUS_OFS;
	localparam logic [3:0] RC = alu_core_pkg::CTRL_OFS;
	localparam logic [1:0] OK = alu_core_pkg::RESP_OKAY;
	localparam logic [1:0] SE = alu_core_pkg::RESP_SLVERR;
	logic                    i_clk;
	logic                    i_arst_n;
	logic [13:0]             i_instr;
	logic                    i_instr_valid;
	logic                    o_instr_ready;
	alu_core_pkg::file_req_t o_file;
	logic [7:0]              i_file_rdata;
	alu_core_pkg::axil_req_t i_axi;
	alu_core_pkg::axil_rsp_t o_axi;
	int                      miscompares;
	int                      compares;
	int                      cycles;
	int                      waited;
	logic [7:0]              m_acc;
	logic [3:0]              m_st;

	add_and_alu_ops dut (
		.i_clk        (i_clk),
		.i_arst_n     (i_arst_n),
		.i_instr      (i_instr),
		.i_instr_valid(i_instr_valid),
		.o_instr_ready(o_instr_ready),
		.o_file       (o_file),
		.i_file_rdata (i_file_rdata),
		.i_axi        (i_axi),
		.o_axi        (o_axi)
	);

	// Free-running clock
	always #5 i_clk = ~i_clk;

	task automatic close_out();
		if (miscompares == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Hang guard, well above the 160 or so cycles the tests need
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		i_axi.awvalid <= 1'b1;
		i_axi.awaddr <= a;
		i_axi.wvalid <= 1'b1;
		i_axi.wdata <= d;
		i_axi.wstrb <= 4'hF;
		i_axi.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge i_clk);
			if (!aw && o_axi.awready === 1'b1) begin
				aw = 1;
				i_axi.awvalid <= 1'b0;
			end
			if (!w && o_axi.wready === 1'b1) begin
				w = 1;
				i_axi.wvalid <= 1'b0;
			end
		end
		do @(posedge i_clk); while (o_axi.bvalid !== 1'b1);
		check(o_axi.bresp, er);
		i_axi.bready <= 1'b0;
	endtask

	task automatic axr(input logic [3:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		i_axi.arvalid <= 1'b1;
		i_axi.araddr <= a;
		i_axi.rready <= 1'b1;
		do @(posedge i_clk); while (o_axi.arready !== 1'b1);
		i_axi.arvalid <= 1'b0;
		do @(posedge i_clk); while (o_axi.rvalid !== 1'b1);
		check(o_axi.rdata, ed);
		check(o_axi.rresp, er);
		i_axi.rready <= 1'b0;
		// An edge passes so a following read never reassigns rready at once
		@(posedge i_clk);
	endtask

	// Accumulator and flags against the bench's own model
	task automatic st();
		axr(RA, {24'h0, m_acc}, OK);
		axr(RS, {28'h0, m_st}, OK);
	endtask

	// One instruction: offer, serve the file read, watch the write-back
	task automatic exec(input logic [13:0] ins, input logic [7:0] fd);
		logic [8:0] s;
		logic [7:0] r;
		logic [7:0] op;
		logic       ad;
		logic       an;
		logic       fl;
		ad = ins[13:9] == 5'h1F || ins[13:8] == 6'h07;
		an = ins[13:8] == 6'h39 || ins[13:8] == 6'h05;
		fl = ins[13:12] == 2'h0;
		op = fl ? fd : ins[7:0];
		s = {1'b0, m_acc} + {1'b0, op};
		r = an ? (m_acc & op) : s[7:0];
		waited = 0;
		i_instr <= ins;
		i_instr_valid <= 1'b1;
		do begin
			@(posedge i_clk);
			waited++;
		end while (o_instr_ready !== 1'b1);
		i_instr_valid <= 1'b0;
		i_file_rdata <= fd;
		#1;
		check(o_file.rd, fl & (ad | an));
		if (fl & (ad | an)) check(o_file.addr, ins[6:0]);
		@(posedge i_clk);
		// Read data invalid outside the read cycle
		i_file_rdata <= ~fd;
		@(posedge i_clk);
		#1;
		check(o_file.we, fl & (ad | an) & ins[7]);
		if (o_file.we === 1'b1) check(o_file.wdata, r);
		if (o_file.we === 1'b1) check(o_file.addr, ins[6:0]);
		@(posedge i_clk);
		if (ad) m_st[1:0] = {({1'b0, m_acc[3:0]} + {1'b0, op[3:0]}) > 5'h0F, s[8]};
		if (ad | an) m_st[2] = r == 8'h00;
		else m_st[3] = 1'b1;
		if ((ad | an) & ~(fl & ins[7])) m_acc = r;
	endtask

	initial begin
		i_clk = 1'b0;
		i_arst_n = 1'b0;
		i_instr = '0;
		i_instr_valid = 1'b0;
		i_file_rdata = 8'hA5;
		i_axi = '0;
		miscompares = 0;
		compares = 0;
		cycles = 0;
		m_acc = 8'h00;
		m_st = 4'h0;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		// Reset values, then unmapped place
		st();
		axr(RC, 32'h1, OK);
		axr(4'hC, 32'h0, SE);
		axw(4'hC, 32'h1, SE);
		m_acc = 8'h10;
		axw(RA, {24'h0, m_acc}, OK);
		exec(14'h3E15, 8'h00);
		st();
		m_acc = 8'h17;
		axw(RA, {24'h0, m_acc}, OK);
		exec(14'h0704, 8'hC2);
		st();
		// Highest file address, sum wraps to zero
		exec(14'h07FF, 8'h27);
		st();
		m_acc = 8'hA3;
		axw(RA, {24'h0, m_acc}, OK);
		exec(14'h395F, 8'h00);
		st();
		exec(14'h0580, 8'h0C);
		st();
		exec(14'h0511, 8'hF1);
		st();
		// Back to back, second encoding of add literal
		exec(14'h3FFF, 8'h00);
		exec(14'h3E08, 8'h00);
		check(waited, 1);
		exec(14'h3E08, 8'h00);
		check(waited, 1);
		st();
		// Foreign opcode only raises its sticky bit
		exec(14'h0000, 8'h00);
		st();
		m_st = 4'h0;
		axw(RS, 32'h8, OK);
		st();
		// Run bit low: no instruction is taken
		axw(RC, 32'h0, OK);
		repeat (8) begin
			@(posedge i_clk);
			check(o_instr_ready, 1'b0);
		end
		axw(RC, 32'h1, OK);
		axr(RC, 32'h1, OK);
		close_out();
	end
endmodule
